// *** hw/dsam_params.svh ***
/*
 Register offsets, field positions, reset values and timing for the
 dual sensor alarm monitor. Assumes byte offsets as seen by the serial port.
*/
`ifndef DSAM_PARAMS_SVH
`define DSAM_PARAMS_SVH

// Register offsets
`define DSAM_ADDR_ALARM1_THRESHOLD 7'h26
`define DSAM_ADDR_ALARM2_THRESHOLD 7'h28
`define DSAM_ADDR_ALARM1_SAMPLE_COUNT 7'h2a
`define DSAM_ADDR_ALARM2_SAMPLE_COUNT 7'h2c
`define DSAM_ADDR_ALARM_CONFIG 7'h2e

// Reset values
`define DSAM_RST_THRESHOLD 16'h0000
`define DSAM_RST_SAMPLE_COUNT 16'h0000
`define DSAM_RST_CONFIG 16'h0000

// alarm_config field positions
`define DSAM_CFG_SRC2_HI 15
`define DSAM_CFG_SRC2_LO 12
`define DSAM_CFG_SRC1_HI 11
`define DSAM_CFG_SRC1_LO 8
`define DSAM_CFG_DYN2 7
`define DSAM_CFG_DYN1 6
`define DSAM_CFG_POL2 5
`define DSAM_CFG_POL1 4
`define DSAM_CFG_FILT 3
`define DSAM_CFG_IND_EN 2
`define DSAM_CFG_IND_POL 1
`define DSAM_CFG_IND_LINE 0

// Diagnostic status bits owned by the alarms
`define DSAM_DIAG_ALARM1_BIT 8
`define DSAM_DIAG_ALARM2_BIT 9

// Sample count field width and the output update rate
`define DSAM_SAMPLE_COUNT_BITS 8
`define DSAM_SAMPLE_RATE_SPS 1024

`endif

// *** hw/dsam_pkg.sv ***
/*
 Types shared by the dual sensor alarm monitor and its surroundings.
 Assumes 16-bit two's complement sensor output words.
*/
package dsam_pkg;

   // One set of sensor output words
   typedef struct packed {
      logic [15:0] aux_adc;
      logic [15:0] temperature;
      logic [15:0] accel_z;
      logic [15:0] accel_y;
      logic [15:0] accel_x;
      logic [15:0] gyro_z;
      logic [15:0] gyro_y;
      logic [15:0] gyro_x;
   } dsam_sensor_set_t;

   // Source selector codes
   typedef enum logic [3:0] {
      DSAM_SRC_OFF = 4'h0,
      DSAM_SRC_GYRO_X = 4'h1,
      DSAM_SRC_GYRO_Y = 4'h2,
      DSAM_SRC_GYRO_Z = 4'h3,
      DSAM_SRC_ACCEL_X = 4'h4,
      DSAM_SRC_ACCEL_Y = 4'h5,
      DSAM_SRC_ACCEL_Z = 4'h6,
      DSAM_SRC_TEMP = 4'h7,
      DSAM_SRC_AUX = 4'h8,
      DSAM_SRC_DIAG = 4'h9
   } dsam_source_t;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } dsam_reg_req_t;

   // Indicator pin pair, output and enable
   typedef struct packed {
      logic line_b_out;
      logic line_b_oe;
      logic line_a_out;
      logic line_a_oe;
   } dsam_dio_t;

endpackage

// *** hw/dsam_monitor.sv ***
/*
 Dual sensor alarm monitor: alarm registers, per-alarm sample history,
 static and rate-of-change checks, diagnostic flags and indicator pins.
 Assumes the serial port decodes frames into single-cycle register
 requests and that sample_strobe pulses once per output update.
*/
// Behaviour
// - Two alarms, each with own threshold, count, source, mode, polarity.
// - Static mode compares selected source with its threshold, same format.
// - Dynamic mode checks change over programmed sample count against threshold.
// - Sample count is low byte, unsigned; zero and one mean one sample.
// - Alarm conditions reported as flags in diagnostic status bits 9 and 8.
// - Config bits 15:12 select alarm 2 source, 11:8 alarm 1.
// - Code 0 disables; 1-3 gyro, 4-6 accel, 7 temperature, 8 auxiliary.
// - Code 9 triggers while diagnostic status is nonzero.
// - Config bit 7 alarm 2 dynamic, bit 6 alarm 1 dynamic.
// - Bits 5 and 4 pick greater-than (1) or less-than (0).
// - Config bit 3 picks filtered or unfiltered data for both alarms.
// - Config bit 2 enables the indicator output.
// - Config bit 1 sets indicator active level.
// - Config bit 0 routes indicator to line b, else line a.
// - Alarm 1 threshold is 16 bits, reset zero, in source format.
// - Alarm 2 threshold is 16 bits, reset zero, in source format.
// - Alarms evaluate once per output update, nominally 1024 per second.
`timescale 1ns/1ps
`include "dsam_params.svh"

module dsam_monitor #(
   parameter int HIST_DEPTH = 256 // Samples kept per alarm, above max count
) (
   input wire logic core_clk, // 200 MHz clock
   input wire logic rst, // Asynchronous reset, active high
   input wire dsam_pkg::dsam_reg_req_t reg_req, // Register request, one cycle
   output logic [15:0] reg_rdata, // Read data, valid cycle after rd
   input wire logic sample_strobe, // One pulse per output update
   input wire dsam_pkg::dsam_sensor_set_t raw_data, // Unfiltered outputs
   input wire dsam_pkg::dsam_sensor_set_t filt_data, // Filtered outputs
   input wire logic [15:0] diagnostic_status_in, // Other diagnostic bits
   output logic [1:0] alarm_flags, // Diagnostic status bits 9:8
   output dsam_pkg::dsam_dio_t dio // Indicator on digital_io_line_a/b
);
   import dsam_pkg::*;

   localparam int PTR_W = $clog2(HIST_DEPTH);

   logic [15:0] thr_reg [2];
   logic [15:0] thr_next [2];
   logic [15:0] cnt_reg [2];
   logic [15:0] cnt_next [2];
   logic [15:0] cfg_reg;
   logic [15:0] cfg_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [15:0] hist_reg [2][HIST_DEPTH];
   logic [PTR_W-1:0] wptr_reg;
   logic [PTR_W-1:0] wptr_next;
   logic [7:0] fill_reg [2];
   logic [7:0] fill_next [2];
   logic [1:0] flag_reg;
   logic [1:0] flag_next;
   dsam_dio_t dio_reg;
   dsam_dio_t dio_next;
   logic [15:0] cur_val [2];
   logic [15:0] old_val [2];
   logic [7:0] span [2];
   logic cond [2];
   logic cfg_touch;

   // Pick a sensor word by selector code
   function automatic logic [15:0] pick_source(input dsam_sensor_set_t s, input logic [3:0] code);
      logic [15:0] v;
      v = 16'h0000;
      case (code)
         DSAM_SRC_GYRO_X: v = s.gyro_x;
         DSAM_SRC_GYRO_Y: v = s.gyro_y;
         DSAM_SRC_GYRO_Z: v = s.gyro_z;
         DSAM_SRC_ACCEL_X: v = s.accel_x;
         DSAM_SRC_ACCEL_Y: v = s.accel_y;
         DSAM_SRC_ACCEL_Z: v = s.accel_z;
         DSAM_SRC_TEMP: v = s.temperature;
         DSAM_SRC_AUX: v = s.aux_adc;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // Signed compare in the chosen sense; equal never triggers
   function automatic logic beyond(input logic signed [16:0] a, input logic signed [16:0] b, input logic gt);
      return gt ? (a > b) : (a < b);
   endfunction

   // Select source, apply mode and polarity for both alarms
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic [3:0] code;
         logic dyn;
         logic gt;
         logic signed [16:0] delta;
         code = (i == 0) ? cfg_reg[`DSAM_CFG_SRC1_HI:`DSAM_CFG_SRC1_LO]
                         : cfg_reg[`DSAM_CFG_SRC2_HI:`DSAM_CFG_SRC2_LO];
         dyn = (i == 0) ? cfg_reg[`DSAM_CFG_DYN1] : cfg_reg[`DSAM_CFG_DYN2];
         gt = (i == 0) ? cfg_reg[`DSAM_CFG_POL1] : cfg_reg[`DSAM_CFG_POL2];
         cur_val[i] = cfg_reg[`DSAM_CFG_FILT] ? pick_source(filt_data, code)
                                              : pick_source(raw_data, code);
         // Zero and one both mean a one-sample span
         span[i] = (cnt_reg[i][7:0] == 8'h00) ? 8'h01 : cnt_reg[i][7:0];
         old_val[i] = hist_reg[i][wptr_reg - PTR_W'(span[i])];
         delta = 17'($signed(cur_val[i])) - 17'($signed(old_val[i]));
         if (code == 4'(DSAM_SRC_OFF) || code > 4'(DSAM_SRC_DIAG)) begin
            cond[i] = 1'b0;
         end else if (code == 4'(DSAM_SRC_DIAG)) begin
            cond[i] = (diagnostic_status_in != 16'h0000);
         end else if (dyn) begin
            // No verdict until the history spans the window
            cond[i] = (fill_reg[i] >= span[i]) && beyond(delta, 17'($signed(thr_reg[i])), gt);
         end else begin
            cond[i] = beyond(17'($signed(cur_val[i])), 17'($signed(thr_reg[i])), gt);
         end
      end
   end

   // Register writes and read mux
   always_comb begin
      thr_next = thr_reg;
      cnt_next = cnt_reg;
      cfg_next = cfg_reg;
      rdata_next = rdata_reg;
      cfg_touch = 1'b0;
      if (reg_req.wr) begin
         case (reg_req.addr)
            `DSAM_ADDR_ALARM1_THRESHOLD: thr_next[0] = reg_req.wdata;
            `DSAM_ADDR_ALARM2_THRESHOLD: thr_next[1] = reg_req.wdata;
            `DSAM_ADDR_ALARM1_SAMPLE_COUNT: begin
               cnt_next[0] = {8'h00, reg_req.wdata[7:0]};
               cfg_touch = 1'b1;
            end
            `DSAM_ADDR_ALARM2_SAMPLE_COUNT: begin
               cnt_next[1] = {8'h00, reg_req.wdata[7:0]};
               cfg_touch = 1'b1;
            end
            `DSAM_ADDR_ALARM_CONFIG: begin
               cfg_next = reg_req.wdata;
               cfg_touch = 1'b1;
            end
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            `DSAM_ADDR_ALARM1_THRESHOLD: rdata_next = thr_reg[0];
            `DSAM_ADDR_ALARM2_THRESHOLD: rdata_next = thr_reg[1];
            `DSAM_ADDR_ALARM1_SAMPLE_COUNT: rdata_next = cnt_reg[0];
            `DSAM_ADDR_ALARM2_SAMPLE_COUNT: rdata_next = cnt_reg[1];
            `DSAM_ADDR_ALARM_CONFIG: rdata_next = cfg_reg;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         thr_reg[0] <= `DSAM_RST_THRESHOLD;
         thr_reg[1] <= `DSAM_RST_THRESHOLD;
         cnt_reg[0] <= `DSAM_RST_SAMPLE_COUNT;
         cnt_reg[1] <= `DSAM_RST_SAMPLE_COUNT;
         cfg_reg <= `DSAM_RST_CONFIG;
         rdata_reg <= 16'h0000;
      end else begin
         thr_reg <= thr_next;
         cnt_reg <= cnt_next;
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // History pointer, fill level and flags advance only on an update
   always_comb begin
      wptr_next = wptr_reg;
      fill_next = fill_reg;
      flag_next = flag_reg;
      if (sample_strobe) begin
         wptr_next = wptr_reg + PTR_W'(1);
         for (int i = 0; i < 2; i++) begin
            fill_next[i] = (fill_reg[i] == 8'hff) ? fill_reg[i] : fill_reg[i] + 8'h01;
            flag_next[i] = cond[i];
         end
      end
      // A new source or span makes the old history meaningless
      if (cfg_touch) begin
         fill_next[0] = 8'h00;
         fill_next[1] = 8'h00;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wptr_reg <= '0;
         fill_reg[0] <= 8'h00;
         fill_reg[1] <= 8'h00;
         flag_reg <= 2'b00;
      end else begin
         wptr_reg <= wptr_next;
         fill_reg <= fill_next;
         flag_reg <= flag_next;
      end
   end

   // Sample history per alarm; no reset, fill level guards stale words
   always_ff @(posedge core_clk) begin
      if (sample_strobe) begin
         hist_reg[0][wptr_reg] <= cur_val[0];
         hist_reg[1][wptr_reg] <= cur_val[1];
      end
   end

   // Indicator level and routing, from the registered flags
   always_comb begin
      logic active;
      logic level;
      active = flag_reg[0] | flag_reg[1];
      level = cfg_reg[`DSAM_CFG_IND_POL] ? active : ~active;
      dio_next = '0;
      if (cfg_reg[`DSAM_CFG_IND_EN]) begin
         if (cfg_reg[`DSAM_CFG_IND_LINE]) begin
            dio_next.line_b_out = level;
            dio_next.line_b_oe = 1'b1;
         end else begin
            dio_next.line_a_out = level;
            dio_next.line_a_oe = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dio_reg <= '0;
      end else begin
         dio_reg <= dio_next;
      end
   end

   // Flag order matches diagnostic status bit 9 over bit 8
   assign alarm_flags = {flag_reg[1], flag_reg[0]};
   assign reg_rdata = rdata_reg;
   assign dio = dio_reg;

endmodule

// *** bench/dsam_monitor_props.sv ***
/*
 Checker for the dual sensor alarm monitor ports.
 Assumes it is bound onto dsam_monitor and keeps its own copy of the config register.
*/
`timescale 1ns/1ps
`include "dsam_params.svh"
module dsam_monitor_props (
   input wire logic core_clk, // Clock
   input wire logic rst, // Async reset
   input wire dsam_pkg::dsam_reg_req_t reg_req, // Register request
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic sample_strobe, // Update pulse
   input wire logic [15:0] diagnostic_status_in, // Other diag bits
   input wire logic [1:0] alarm_flags, // Alarm flags
   input wire dsam_pkg::dsam_dio_t dio // Indicator pins
);
   import dsam_pkg::*;
   logic [15:0] cfg_q;

   // Shadow config, so pin checks need no look inside the design
   always_ff @(posedge core_clk or posedge rst)
      if (rst) cfg_q <= 16'h0000;
      else if (reg_req.wr && reg_req.addr == `DSAM_ADDR_ALARM_CONFIG) cfg_q <= reg_req.wdata;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   flags_hold_a: assert property (!sample_strobe |=> $stable(alarm_flags))
      else $error("alarm flags changed without a strobe");
   line_a_oe_a: assert property (dio.line_a_oe == ($past(cfg_q[2]) && !$past(cfg_q[0])))
      else $error("line a enable wrong");
   line_b_oe_a: assert property (dio.line_b_oe == ($past(cfg_q[2]) && $past(cfg_q[0])))
      else $error("line b enable wrong");
   level_a_a: assert property (dio.line_a_oe |-> dio.line_a_out == ($past(cfg_q[1]) ~^ |$past(alarm_flags)))
      else $error("line a level wrong");
   level_b_a: assert property (dio.line_b_oe |-> dio.line_b_out == ($past(cfg_q[1]) ~^ |$past(alarm_flags)))
      else $error("line b level wrong");
   read_cfg_a: assert property (reg_req.rd && reg_req.addr == 7'h2e |=> reg_rdata == $past(cfg_q))
      else $error("config read back wrong");
   unmapped_a: assert property (reg_req.rd && !(reg_req.addr inside {7'h26, 7'h28, 7'h2a, 7'h2c, 7'h2e})
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   off_one_a: assert property (sample_strobe && (cfg_q[11:8] == 4'h0 || cfg_q[11:8] > 4'h9) |=> !alarm_flags[0])
      else $error("disabled alarm 1 raised");
   off_two_a: assert property (sample_strobe && cfg_q[15:12] == 4'h0 |=> !alarm_flags[1])
      else $error("disabled alarm 2 raised");
   diag_src_a: assert property (sample_strobe && cfg_q[11:8] == 4'h9 && !cfg_q[6]
      |=> alarm_flags[0] == |$past(diagnostic_status_in))
      else $error("diag source alarm wrong");

   // Main scenarios reached
   cover property (sample_strobe ##1 alarm_flags == 2'b11);
   cover property (dio.line_b_oe && dio.line_b_out);
   cover property (dio.line_a_oe && !dio.line_a_out);
endmodule

bind dsam_monitor dsam_monitor_props dsam_monitor_props_i (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .diagnostic_status_in(diagnostic_status_in),
   .alarm_flags(alarm_flags), .dio(dio));

// *** bench/dsam_host_model.sv ***
/*
 Host side of the register port: single-cycle requests.
 Assumes requests change on the falling edge of core_clk.
*/
`timescale 1ns/1ps
module dsam_host_model (
   input wire logic core_clk, // Clock
   output dsam_pkg::dsam_reg_req_t reg_req, // Request to block
   input wire logic [15:0] reg_rdata // Read data from block
);
   import dsam_pkg::*;
   logic [15:0] rd_val;
   initial reg_req = '0;

   // One request; data taken at the falling edge after the read edge, as the port answers
   task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge core_clk);
      reg_req <= '0;
      rd_val = reg_rdata;
   endtask
endmodule

// *** bench/dual_sensor_alarm_monitor_tb.sv ***
/*
 Testbench for the dual sensor alarm monitor: registers, static and rate alarms, pins.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module dual_sensor_alarm_monitor_tb;
   import dsam_pkg::*;
   logic core_clk = 0, rst = 1, sample_strobe = 0;
   dsam_reg_req_t reg_req;
   logic [15:0] reg_rdata, cfg, th1, th2, v, diag_in = '0;
   dsam_sensor_set_t raw = '0, filt = '0;
   logic [1:0] flags, e;
   dsam_dio_t dio;
   int n_fail = 0, compares = 0, seed = 32'h1e92, span, step;
   int cnts[4] = '{0, 1, 3, 255};

   dsam_monitor dsam_monitor_i (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .sample_strobe(sample_strobe), .raw_data(raw), .filt_data(filt), .diagnostic_status_in(diag_in),
      .alarm_flags(flags), .dio(dio));
   dsam_host_model dsam_host_model_i (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

   initial forever #2.5 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      dsam_host_model_i.xfer(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      dsam_host_model_i.xfer(1'b0, a, 16'h0000);
      chk("register read", dsam_host_model_i.rd_val, exp);
   endtask

   // Strobe held for exactly one rising edge
   task automatic pulse();
      @(negedge core_clk) sample_strobe = 1;
      @(negedge core_clk) sample_strobe = 0;
   endtask

   // Level alarm; equal values never trigger
   function automatic logic exp_static(input logic [3:0] s, input logic p, input dsam_sensor_set_t d,
      input logic [15:0] th);
      logic [15:0] x;
      if (s == 4'h9) return diag_in != 16'h0000;
      if (s == 4'h0 || s > 4'h9) return 1'b0;
      x = d[(int'(s) - 1) * 16 +: 16];
      return p ? $signed(x) > $signed(th) : $signed(x) < $signed(th);
   endfunction

   // Pins with undriven outputs masked; bit order is b_out, b_oe, a_out, a_oe as in the pin struct
   function automatic logic [3:0] exp_dio(input logic [15:0] c, input logic [1:0] f);
      logic l;
      l = c[1] ~^ (|f);
      return {c[2] & c[0] & l, c[2] & c[0], c[2] & ~c[0] & l, c[2] & ~c[0]};
   endfunction

   initial begin
      repeat (5) @(negedge core_clk);
      rst = 0;
      for (int i = 0; i < 5; i++) rd_chk(7'h26 + 7'(2 * i), 16'h0000);
      for (int i = 0; i < 5; i++) begin
         v = 16'($random(seed));
         wr(7'h26 + 7'(2 * i), v);
         rd_chk(7'h26 + 7'(2 * i), (i == 2 || i == 3) ? {8'h00, v[7:0]} : v);
      end
      rd_chk(7'h30, 16'h0000);
      $display("register test done");
      // Every source code on both alarms, random polarity, filter and pin setup
      for (int i = 0; i < 48; i++) begin
         cfg = {4'(i % 11), 4'((i + 5) % 11), 2'b00, 6'($random(seed))};
         for (int k = 0; k < 8; k++) begin
            raw[k * 16 +: 16] = 16'($random(seed));
            filt[k * 16 +: 16] = 16'($random(seed));
         end
         th1 = 16'($random(seed));
         th2 = 16'($random(seed));
         if (i % 4 == 1 && cfg[11:8] inside {[1:8]}) th1 = 16'((cfg[3] ? filt : raw) >> (16 * (cfg[11:8] - 1)));
         diag_in = (i % 3 == 0) ? 16'($random(seed)) : 16'h0000;
         wr(7'h26, th1);
         wr(7'h28, th2);
         wr(7'h2e, cfg);
         pulse();
         e = {exp_static(cfg[15:12], cfg[5], cfg[3] ? filt : raw, th2), exp_static(cfg[11:8], cfg[4], cfg[3] ? filt : raw, th1)};
         chk("alarm flags", 16'(flags), 16'(e));
         @(negedge core_clk);
         chk("indicator pins", 16'(dio & {dio.line_b_oe, 1'b1, dio.line_a_oe, 1'b1}), 16'(exp_dio(cfg, e)));
      end
      $display("static test done");
      // Ramp on filtered gyro x, flat raw data; threshold one below and equal to the change
      raw = '0;
      diag_in = '0;
      for (int c = 0; c < 4; c++) begin
         span = cnts[c] < 2 ? 1 : cnts[c];
         step = 1 + ($random(seed) & 15);
         for (int k = 0; k < 2; k++) begin
            wr(7'h26, 16'(span * step - 1 + k));
            wr(7'h28, 16'(span * step - 1 + k));
            wr(7'h2a, 16'(cnts[c]));
            wr(7'h2c, 16'(cnts[c]));
            wr(7'h2e, 16'h11f8);
            for (int n = 0; n < span + 3; n++) begin
               filt.gyro_x = 16'(n * step);
               pulse();
            end
            chk("rate alarm", 16'(flags), (k == 0) ? 16'h0003 : 16'h0000);
         end
      end
      $display("dynamic test done");
      close_out();
   end

   // Hang guard ending in the same report
   initial begin
      #400us;
      n_fail++;
      $display("[ERR] run end expected finish seen hang");
      close_out();
   end
endmodule
